// ===== rtl/snhs_device.sv
// memory device end: pause, sleep and identity readout
// Contract
// - pause request low with clock low suspends
// - pause request high with clock low resumes
// - master changes pause request only clock low
// - clock edges during pause never advance transfer
// - sleep opcode then chip select rise sleeps
// - asleep: ignore clock and input, output floats
// - chip select fall wakes, ready within recovery
// - output floats throughout wake-up interval
// - device ignores opcodes sent while waking
// - master wakes with dummy read, waits recovery
// - identity opcode shifts maker then product bytes
// - six continuation bytes, maker byte, upper 56
// - product fields family density sub rev reserved
// - recovery never exceeds 400 microseconds
// - chip select rise ends read, floats output
// - output floats while paused, driven after
`timescale 1ns/1ps
module snhs_device
	import snhs_pkg::*;
#(
	parameter int WAKE_CYCLES = snhs_pkg::SNHS_WAKE_CYCLES
)
(
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic reset_i,
	// serial link
	snhs_if.device    link,
	// user side status
	output logic      asleep_o,
	output logic      waking_o,
	output logic      paused_o,
	output logic      cmd_valid_o,
	output logic [7:0] cmd_o
);
	import snhs_pkg::*;

	typedef enum logic [1:0]
	{
		SNHS_AWAKE = 2'b00,
		SNHS_SLEEP = 2'b01,
		SNHS_WAKE  = 2'b10
	} snhs_pwr_t;

	localparam logic [SNHS_ID_BITS-1:0] ID_WORD =
	{
		{SNHS_CONT_COUNT{SNHS_ID_CONT}}, SNHS_ID_MAKER,
		SNHS_ID_FAMILY, SNHS_ID_DENSITY, SNHS_ID_SUB,
		SNHS_ID_REV, SNHS_ID_RSVD
	};

	logic [2:0]  sck_s;
	logic [2:0]  cs_s;
	logic [1:0]  mosi_s;
	logic [1:0]  hold_s;
	logic        sck_rise;
	logic        cs_rise;
	logic        cs_fall;
	logic        paused;
	logic [2:0]  bit_cnt;
	logic [7:0]  shift_in;
	logic        op_done;
	logic        sleep_armed;
	logic        id_mode;
	logic [6:0]  id_ptr;
	logic        drive;
	logic        miso;
	snhs_pwr_t   pwr;
	logic [31:0] wake_cnt;

	// two-stage synchronisers, third stage for edge detection
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			sck_s  <= 3'h0;
			cs_s   <= 3'h7;
			mosi_s <= 2'h0;
			hold_s <= 2'h3;
		end
		else
		begin
			sck_s  <= {sck_s[1:0], link.sck};
			cs_s   <= {cs_s[1:0], link.cs_n};
			mosi_s <= {mosi_s[0], link.mosi};
			hold_s <= {hold_s[0], link.hold_n};
		end
	end

	assign sck_rise = sck_s[1] & ~sck_s[2];
	assign cs_rise  = cs_s[1] & ~cs_s[2];
	assign cs_fall  = ~cs_s[1] & cs_s[2];

	// pause request sampled only while the clock is low
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i || cs_s[1])
			paused <= 1'b0;
		else if (!sck_s[1] && !hold_s[1])
			paused <= 1'b1;
		else if (!sck_s[1] && hold_s[1])
			paused <= 1'b0;
	end

	// opcode shift and identity readout, frozen while paused
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			bit_cnt  <= 3'h0;
			shift_in <= 8'h00;
			op_done  <= 1'b0;
			id_mode  <= 1'b0;
			id_ptr   <= 7'h00;
			cmd_valid_o <= 1'b0;
			cmd_o    <= 8'h00;
		end
		else if (cs_s[1] || pwr != SNHS_AWAKE)
		begin
			bit_cnt  <= 3'h0;
			op_done  <= 1'b0;
			id_mode  <= 1'b0;
			id_ptr   <= 7'h00;
			cmd_valid_o <= 1'b0;
		end
		else if (!paused)
		begin
			cmd_valid_o <= 1'b0;
			if (sck_rise && !op_done)
			begin
				shift_in <= {shift_in[6:0], mosi_s[1]};
				bit_cnt  <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7)
				begin
					op_done     <= 1'b1;
					cmd_valid_o <= 1'b1;
					cmd_o       <= {shift_in[6:0], mosi_s[1]};
					id_mode <= ({shift_in[6:0], mosi_s[1]}
						== SNHS_OP_READ_ID);
				end
			end
			// next bit msb first after each rising edge
			// stepping right after the sample leaves a whole clock
			// period for the bit to cross both synchronisers, and
			// a pause in the low phase finds the bit already set
			if (sck_rise && id_mode &&
				id_ptr != 7'(SNHS_ID_BITS - 1))
				id_ptr <= id_ptr + 7'h1;
		end
	end

	// sleep opcode armed until chip select next falls
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			sleep_armed <= 1'b0;
		else if (cs_fall)
			sleep_armed <= 1'b0;
		else if (op_done && shift_in == SNHS_OP_SLEEP)
			sleep_armed <= 1'b1;
	end

	// power state: awake, asleep, waking
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			pwr      <= SNHS_AWAKE;
			wake_cnt <= 32'h0;
		end
		else
		begin
			unique case (pwr)
				SNHS_AWAKE:
				begin
					if (cs_rise && sleep_armed)
						pwr <= SNHS_SLEEP;
				end
				SNHS_SLEEP:
				begin
					if (cs_fall)
					begin
						pwr      <= SNHS_WAKE;
						wake_cnt <= 32'h0;
					end
				end
				SNHS_WAKE:
				begin
					if (wake_cnt >= 32'(WAKE_CYCLES - 1))
						pwr <= SNHS_AWAKE;
					else
						wake_cnt <= wake_cnt + 32'h1;
				end
				default:
					pwr <= SNHS_AWAKE;
			endcase
		end
	end

	// output data register and enable
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			drive <= 1'b0;
			miso  <= 1'b1;
		end
		else
		begin
			drive <= id_mode && !paused && !cs_s[1] &&
				pwr == SNHS_AWAKE;
			miso  <= ID_WORD[7'(SNHS_ID_BITS - 1) - id_ptr];
		end
	end

	assign link.miso_o  = miso;
	assign link.miso_oe = drive;
	assign asleep_o     = (pwr == SNHS_SLEEP);
	assign waking_o     = (pwr == SNHS_WAKE);
	assign paused_o     = paused;
endmodule

// ===== rtl/snhs_pkg.sv
// shared constants for the serial memory pause, sleep and identity link
package snhs_pkg;
	localparam logic [7:0] SNHS_OP_SLEEP     = 8'hB9;
	localparam logic [7:0] SNHS_OP_READ_ID   = 8'h9F;
	localparam int         SNHS_ID_BYTES     = 9;
	localparam int         SNHS_ID_BITS      = 72;
	// identity fields: continuation and maker bytes are arbitrary values
	localparam logic [7:0] SNHS_ID_CONT      = 8'h5A;
	localparam logic [7:0] SNHS_ID_MAKER     = 8'h3C;
	localparam logic [2:0] SNHS_ID_FAMILY    = 3'h1;
	localparam logic [4:0] SNHS_ID_DENSITY   = 5'h03;
	localparam logic [1:0] SNHS_ID_SUB       = 2'h0;
	localparam logic [2:0] SNHS_ID_REV       = 3'h0;
	localparam logic [2:0] SNHS_ID_RSVD      = 3'h0;
	localparam int         SNHS_CONT_COUNT   = 6;
	// wake recovery time in ns and its cycle count at 200 MHz
	localparam int         SNHS_CLK_PERIOD_NS = 5;
	localparam int         SNHS_WAKE_RECOVERY_TIME_NS = 400000;
	localparam int         SNHS_WAKE_CYCLES =
		SNHS_WAKE_RECOVERY_TIME_NS / SNHS_CLK_PERIOD_NS;
	// master clock divider: half period in system cycles
	localparam int         SNHS_SCK_HALF     = 4;
	localparam int         SNHS_BUF_DEPTH    = 2;
endpackage

// ===== rtl/snhs_if.sv
// serial link between the bus master and the memory device
`timescale 1ns/1ps
interface snhs_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic hold_n;
	logic miso_o;
	logic miso_oe;
	modport master
	(
		output sck,
		output cs_n,
		output mosi,
		output hold_n,
		input  miso_o,
		input  miso_oe
	);
	modport device
	(
		input  sck,
		input  cs_n,
		input  mosi,
		input  hold_n,
		output miso_o,
		output miso_oe
	);
endinterface

// ===== rtl/snhs_master.sv
// bus master end: byte transfers with pause and two-entry buffer
`timescale 1ns/1ps
module snhs_master
	import snhs_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       reset_i,
	// serial link
	snhs_if.master          link,
	// transmit byte stream
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_last_i,
	output logic            tx_ready_o,
	// pause request from user
	input  wire logic       pause_i,
	// received bytes
	output logic            rx_valid_o,
	output logic [7:0]      rx_data_o,
	input  wire logic       rx_ready_i,
	output logic            busy_o
);
	import snhs_pkg::*;

	logic [1:0]  miso_s;
	logic [2:0]  div;
	logic        sck;
	logic        cs_n;
	logic        hold_n;
	logic [7:0]  sh_out;
	logic [7:0]  sh_in;
	logic [2:0]  bit_cnt;
	logic        active;
	logic        last;
	logic [7:0]  buf_mem [SNHS_BUF_DEPTH];
	logic [1:0]  buf_cnt;
	logic        wr_ptr;
	logic        rd_ptr;
	logic        push;
	logic        pop;

	// miso passes two flip-flops before use
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			miso_s <= 2'h3;
		else
			miso_s <= {miso_s[0], link.miso_o};
	end

	// a full buffer stalls the next byte
	assign tx_ready_o = !active && cs_n && buf_cnt == 2'h0 ||
		!active && !cs_n && buf_cnt < 2'h2 && hold_n;
	assign push = active && sck && bit_cnt == 3'h7 &&
		div == 3'(SNHS_SCK_HALF - 1) && hold_n;

	// clock divider, byte shifter, pause control
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			div     <= 3'h0;
			sck     <= 1'b0;
			cs_n    <= 1'b1;
			hold_n  <= 1'b1;
			sh_out  <= 8'h00;
			sh_in   <= 8'h00;
			bit_cnt <= 3'h0;
			active  <= 1'b0;
			last    <= 1'b0;
		end
		else if (!active)
		begin
			// pause changes only with clock low
			if (!sck)
				hold_n <= !pause_i;
			if (tx_valid_i && tx_ready_o)
			begin
				active  <= 1'b1;
				cs_n    <= 1'b0;
				sh_out  <= tx_data_i;
				last    <= tx_last_i;
				bit_cnt <= 3'h0;
				div     <= 3'h0;
			end
			else if (last)
				cs_n <= 1'b1;
		end
		else if (hold_n)
		begin
			// mid-byte pause early in low phase
			// never on a toggle edge, so the far end sees the
			// request strictly inside the low phase
			if (!sck && div == 3'h1 && pause_i)
				hold_n <= 1'b0;
			else if (div == 3'(SNHS_SCK_HALF - 1))
			begin
				div <= 3'h0;
				sck <= !sck;
				if (!sck)
					sh_in <= {sh_in[6:0], miso_s[1]};
				else
				begin
					sh_out  <= {sh_out[6:0], 1'b0};
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == 3'h7)
						active <= 1'b0;
				end
			end
			else
				div <= div + 3'h1;
		end
		// resume restarts the low phase so output is enabled in time
		else if (!sck)
		begin
			hold_n <= !pause_i;
			div    <= 3'h0;
		end
	end

	// busy while shifting or while the frame stays selected
	assign busy_o = active || !cs_n;

	// two-entry receive buffer
	assign pop = rx_valid_o && rx_ready_i;
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			buf_cnt <= 2'h0;
			wr_ptr  <= 1'b0;
			rd_ptr  <= 1'b0;
		end
		else
		begin
			// the byte is complete after the eighth rising edge
			if (push && buf_cnt < 2'h2)
			begin
				buf_mem[wr_ptr] <= sh_in;
				wr_ptr <= !wr_ptr;
			end
			if (pop)
				rd_ptr <= !rd_ptr;
			buf_cnt <= buf_cnt + 2'(push && buf_cnt < 2'h2) - 2'(pop);
		end
	end

	assign rx_valid_o = buf_cnt != 2'h0;
	assign rx_data_o  = buf_mem[rd_ptr];
	assign link.sck    = sck;
	assign link.cs_n   = cs_n;
	assign link.mosi   = sh_out[7];
	assign link.hold_n = hold_n;
endmodule

// ===== tb/snhs_props.sv
// concurrent checks on the serial link between the two ends
`timescale 1ns/1ps
module snhs_props
	import snhs_pkg::*;
#(
	parameter int WAKE_CYCLES = SNHS_WAKE_CYCLES
)
(
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic reset_i,
	// serial link
	input  wire logic sck,
	input  wire logic cs_n,
	input  wire logic mosi,
	input  wire logic hold_n,
	input  wire logic miso_o,
	input  wire logic miso_oe
);
	logic        sck_q;
	logic        cs_q;
	logic [7:0]  op;
	logic [6:0]  cnt;
	logic        asleep;
	logic        ign;
	int          wake_cnt;
	wire  [71:0] id_word = {{6{SNHS_ID_CONT}}, SNHS_ID_MAKER,
		SNHS_ID_FAMILY, SNHS_ID_DENSITY, SNHS_ID_SUB, SNHS_ID_REV,
		SNHS_ID_RSVD};
	wire         rise = sck & ~sck_q;
	wire         id_bit = ~cs_n & ~ign & hold_n & (op == SNHS_OP_READ_ID)
		& (cnt >= 7'd8) & (cnt < 7'd80);

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	// edge history of clock and select
	always_ff @(posedge clk_sys_i)
	begin
		sck_q <= reset_i ? 1'b0 : sck;
		cs_q <= reset_i ? 1'b1 : cs_n;
	end

	// opcode and bit count, frozen while paused
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i || cs_n)
		begin
			cnt <= 7'h00;
			op <= 8'h00;
		end
		else if (rise && hold_n)
		begin
			cnt <= cnt + 7'h01;
			if (cnt < 7'h08)
				op <= {op[6:0], mosi};
		end
	end

	// sleep state and wake interval as seen on the wire
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			asleep <= 1'b0;
			ign <= 1'b0;
			wake_cnt <= 0;
		end
		else
		begin
			if (cs_n && !cs_q && cnt == 7'h08 && op == SNHS_OP_SLEEP)
				asleep <= 1'b1;
			else if (!cs_n && cs_q)
				asleep <= 1'b0;
			if (!cs_n && cs_q)
				ign <= asleep || (wake_cnt != 0);
			if (!cs_n && cs_q && asleep)
				wake_cnt <= WAKE_CYCLES;
			else if (wake_cnt != 0)
				wake_cnt <= wake_cnt - 1;
		end
	end

	a_cs_float: assert property (cs_n [*4] |-> !miso_oe)
		else $error("output driven while deselected");
	a_cs_end_low: assert property ($rose(cs_n) |-> !sck)
		else $error("select rose with clock high");
	a_hold_edge: assert property ($changed(hold_n) |-> !sck)
		else $error("pause request moved with clock high");
	a_hold_float: assert property ((!hold_n) [*6] |-> !miso_oe)
		else $error("output driven while paused");
	a_sleep_float: assert property (asleep |-> !miso_oe)
		else $error("output driven while asleep");
	a_wake_float: assert property ((wake_cnt != 0) |-> !miso_oe)
		else $error("output driven while waking");
	a_id_bits: assert property (
		rise && id_bit |-> miso_o == id_word[7'd79 - cnt])
		else $error("identity bit wrong");
	a_id_drive: assert property (rise && id_bit |-> miso_oe)
		else $error("identity bit not driven");
endmodule

// ===== tb/spi_nvram_hold_sleep_ident_test.sv
// bench for the pause, sleep and identity serial link
`timescale 1ns/1ps
module spi_nvram_hold_sleep_ident_test;
	import snhs_pkg::*;
	localparam int WAKE = 50;
	logic       clk_sys_i = 1'b0;
	logic       reset_i = 1'b1;
	logic       tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic       tx_last = 1'b0;
	logic       pause = 1'b0;
	logic       rx_ready = 1'b0;
	logic       tx_ready, rx_valid, busy, asleep, waking, paused, cmd_v;
	logic [7:0] rx_data, cmd;
	logic [7:0] rxq[$];
	int         error_cnt = 0;
	int         total_checks = 0;
	int         cmd_cnt = 0;
	wire [71:0] id_word = {{6{SNHS_ID_CONT}}, SNHS_ID_MAKER,
		SNHS_ID_FAMILY, SNHS_ID_DENSITY, SNHS_ID_SUB, SNHS_ID_REV,
		SNHS_ID_RSVD};

	snhs_if link();
	snhs_master snhs_master_i(.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.link(link), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
		.tx_last_i(tx_last), .tx_ready_o(tx_ready), .pause_i(pause),
		.rx_valid_o(rx_valid), .rx_data_o(rx_data),
		.rx_ready_i(rx_ready), .busy_o(busy));
	snhs_device #(.WAKE_CYCLES(WAKE)) snhs_device_i(.clk_sys_i(clk_sys_i),
		.reset_i(reset_i), .link(link), .asleep_o(asleep),
		.waking_o(waking), .paused_o(paused), .cmd_valid_o(cmd_v),
		.cmd_o(cmd));
	snhs_props #(.WAKE_CYCLES(WAKE)) snhs_props_i(.clk_sys_i(clk_sys_i),
		.reset_i(reset_i), .sck(link.sck), .cs_n(link.cs_n),
		.mosi(link.mosi), .hold_n(link.hold_n), .miso_o(link.miso_o),
		.miso_oe(link.miso_oe));

	// system clock
	initial
	begin
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	// collect received bytes
	always @(posedge clk_sys_i)
	begin
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			rxq.push_back(rx_data);
	end

	// count opcode strobes from the device
	always @(posedge clk_sys_i)
	begin
		if (cmd_v === 1'b1)
			cmd_cnt++;
	end

	// a handshake that never completes ends the run as a failure
	task automatic limit(input int w);
		if (w >= 4000)
		begin
			error_cnt++;
			$display("[ERR] %0t handshake timeout", $time);
			results();
		end
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// one frame: opcode then zero bytes, optional pause during byte pz
	task automatic frame(input int n, input logic [7:0] op, input int pz);
		int k;
		int w;
		rxq.delete();
		cmd_cnt = 0;
		tx_valid = 1'b1;
		for (k = 0; k < n; k++)
		begin
			tx_data = (k == 0) ? op : 8'h00;
			tx_last = (k == n - 1);
			w = 0;
			@(posedge clk_sys_i);
			while (tx_ready !== 1'b1 && w < 4000)
			begin
				w++;
				@(posedge clk_sys_i);
			end
			limit(w);
			#1;
			if (k == pz)
			begin
				repeat (20) @(posedge clk_sys_i);
				#1;
				pause = 1'b1;
				repeat (100) @(posedge clk_sys_i);
				check({7'h00, paused}, 8'h01);
				check({7'h00, link.miso_oe}, 8'h00);
				#1;
				pause = 1'b0;
			end
		end
		tx_valid = 1'b0;
		tx_last = 1'b0;
		w = 0;
		@(posedge clk_sys_i);
		while (busy !== 1'b0 && w < 4000)
		begin
			w++;
			@(posedge clk_sys_i);
		end
		limit(w);
		repeat (4) @(posedge clk_sys_i);
		check({6'h00, link.cs_n, link.miso_oe}, 8'h02);
		#1;
	endtask

	// received identity bytes after the opcode byte
	task automatic check_id();
		int i;
		check(8'(rxq.size()), 8'h0A);
		for (i = 1; i < 10 && i < rxq.size(); i++)
			check(rxq[i], id_word[8 * (10 - i) - 1 -: 8]);
		check(cmd, SNHS_OP_READ_ID);
		check(8'(cmd_cnt), 8'h01);
	endtask

	// watchdog against a hung handshake
	initial
	begin
		#200000;
		error_cnt++;
		$display("[ERR] %0t watchdog expired", $time);
		results();
	end

	// main sequence
	initial
	begin
		repeat (5) @(posedge clk_sys_i);
		#1;
		reset_i = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1;
		// identity read with the receiver stalled until the buffer refuses
		fork
			frame(10, SNHS_OP_READ_ID, -1);
			begin
				repeat (300) @(posedge clk_sys_i);
				check({7'h00, tx_ready}, 8'h00);
				#1;
				rx_ready = 1'b1;
			end
		join
		check_id();
		// identity read paused in mid-transfer must come out unchanged
		frame(10, SNHS_OP_READ_ID, 3);
		check_id();
		// sleep, then a throwaway read to wake, then a real read
		frame(1, SNHS_OP_SLEEP, -1);
		repeat (10) @(posedge clk_sys_i);
		check({7'h00, asleep}, 8'h01);
		check({7'h00, link.miso_oe}, 8'h00);
		#1;
		fork
			frame(10, SNHS_OP_READ_ID, -1);
			begin
				repeat (20) @(posedge clk_sys_i);
				check({7'h00, waking}, 8'h01);
				check({7'h00, link.miso_oe}, 8'h00);
			end
		join
		check({6'h00, asleep, waking}, 8'h00);
		frame(10, SNHS_OP_READ_ID, -1);
		check_id();
		results();
	end
endmodule
